// [hw/asbt_defs.vh]
// timing and code constants for the async static memory controller
`ifndef ASBT_DEFS_VH
`define ASBT_DEFS_VH

// clock period in picoseconds (125 MHz)
`define ASBT_CLK_PS            8000
// documented times in picoseconds
`define ASBT_READ_PERIOD_PS    45000
`define ASBT_ADDR_ACCESS_PS    45000
`define ASBT_ADDR_CHANGE_PS    10000
`define ASBT_DRIVE_EN_PS       22000
`define ASBT_ADDR_SETUP_END_PS 35000
`define ASBT_ADDR_SETUP_BEG_PS 0
`define ASBT_ADDR_HOLD_PS      0
`define ASBT_WDATA_SETUP_PS    25000
`define ASBT_WDATA_HOLD_PS     0
`define ASBT_TURNOFF_PS        18000
`define ASBT_WRITE_PERIOD_PS   45000
`define ASBT_STROBE_LOW_PS     35000
`define ASBT_RETENTION_PS      0
// least times round up to whole cycles, at least one
`define ASBT_CEIL(ps) ((((ps) + `ASBT_CLK_PS - 1) / `ASBT_CLK_PS) < 1 ? 1 : \
    (((ps) + `ASBT_CLK_PS - 1) / `ASBT_CLK_PS))
// data sampled one cycle past the access limit after address settles
`define ASBT_RD_CYC     (`ASBT_CEIL(`ASBT_ADDR_ACCESS_PS) + 1)
`define ASBT_WR_CYC     `ASBT_CEIL(`ASBT_STROBE_LOW_PS + `ASBT_TURNOFF_PS)
`define ASBT_GAP_CYC    `ASBT_CEIL(`ASBT_TURNOFF_PS)
`define ASBT_PERIOD_CYC `ASBT_CEIL(`ASBT_WRITE_PERIOD_PS)
`define ASBT_CNT_W      4
`define ASBT_CNT_ZERO   4'h0
`define ASBT_CNT_ONE    4'h1

`endif

// [hw/asbt_delay_cnt.v]
// down counter that times each bus phase
`timescale 1ns/1ps
module asbt_delay_cnt #(
    parameter W = 4
) (
    input  wire         sys_clk_in,  // clock
    input  wire         nrst_in,     // sync reset, low
    input  wire         load_in,     // load start value
    input  wire [W-1:0] value_in,    // cycles to count
    output wire         done_out     // count reached zero
);
    reg [W-1:0] count;

    // count down after load, stop at zero
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            count <= {W{1'b0}};
        end else if (load_in) begin
            count <= value_in;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_out = (count == {W{1'b0}});
endmodule

// [hw/asbt_host.v]
// host controller driving a byte-wide asynchronous static memory
// Overview of operation
// [RL1] a write runs only while strobe low, low select low and high select high; any release ends it
// [RL2] write data setup and hold are measured from the edge that ends the overlap
// [RL3] the address stays stable at least 35.0 ns before write end
// [RL4] a write may start as the address becomes valid, with 0 ns lead
// [RL5] the address may change right at write end, 0 ns hold
// [RL6] write data are valid at least 25.0 ns before the ending edge
// [RL7] write data may be released at the ending edge, 0 ns hold
// [RL8] the memory gives read data within 45.0 ns of the address settling
// [RL9] the memory keeps old read data at least 10.0 ns after an address change
// [RL10] with selects active, read data are valid within 22.0 ns of drive enable low
// [RL11] with drive enable low, strobe low time covers turn-off delay plus data setup
// [RL12] the memory releases its outputs faster than it drives them again
// [RL13] the memory is deselected before retention, with no delay required
// [RL14] the memory is selected only with low select low and high select high
// [RL15] the memory floats its data lines when deselected or drive enable is high
// [RL16] cycles are spaced 45 ns, strobe low and selects held at least 35 ns before write end
// [RL17] the host never drives data within 18 ns after drive enable rises or strobe falls
`timescale 1ns/1ps
`include "asbt_defs.vh"
module asbt_host #(
    parameter AW = 21,
    parameter DW = 8
) (
    input  wire          sys_clk_in,            // clock 125 MHz
    input  wire          nrst_in,               // sync reset, low
    input  wire          req_valid_in,          // request present
    input  wire          req_write_in,          // 1 write, 0 read
    input  wire [AW-1:0] req_addr_in,           // request address
    input  wire [DW-1:0] req_wdata_in,          // request write data
    output wire          req_ready_out,         // request taken
    output reg  [DW-1:0] rsp_rdata_out,         // read data
    output reg           rsp_valid_out,         // read data pulse
    input  wire          retain_req_in,         // ask for retention
    output wire          retain_ok_out,         // safe to drop supply
    output reg  [AW-1:0] mem_addr_out,          // memory address
    output reg           select_low_active_out, // low-active select
    output reg           select_high_active_out,// high-active select
    output reg           strobe_n_out,          // write strobe, low
    output reg           drive_enable_n_out,    // output enable, low
    input  wire [DW-1:0] mem_data_in,           // data pin input
    output reg  [DW-1:0] mem_data_out,          // data pin output
    output reg           mem_data_oe_out        // host drives data
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_READ  = 3'h1;
    localparam ST_WGAP  = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_REC   = 3'h4;
    localparam ST_RET   = 3'h5;

    reg [2:0]          state;
    reg [2:0]          next_state;
    reg [DW-1:0]       data_meta;
    reg [DW-1:0]       data_sync;
    reg                ret_meta;
    reg                ret_sync;
    reg                cnt_load;
    reg [`ASBT_CNT_W-1:0] cnt_value;
    wire               cnt_done;

    // phase lengths cut to the counter width on purpose
    localparam [31:0] RD_CYC_FULL  = `ASBT_RD_CYC;
    localparam [31:0] WR_CYC_FULL  = `ASBT_WR_CYC;
    localparam [31:0] GAP_CYC_FULL = `ASBT_GAP_CYC;
    localparam [`ASBT_CNT_W-1:0] RD_CNT  = RD_CYC_FULL[`ASBT_CNT_W-1:0];
    localparam [`ASBT_CNT_W-1:0] WR_CNT  = WR_CYC_FULL[`ASBT_CNT_W-1:0];
    localparam [`ASBT_CNT_W-1:0] GAP_CNT = GAP_CYC_FULL[`ASBT_CNT_W-1:0];

    // selected only with both selects active
    function sel_active;
        input lo_n;
        input hi;
        begin
            sel_active = !lo_n && hi; // [RL14]
        end
    endfunction

    // two stages on pin inputs before use
    // read data are sampled long after they settle, so the bus needs no handshake
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            data_meta <= {DW{1'b0}};
            data_sync <= {DW{1'b0}};
            ret_meta  <= 1'b0;
            ret_sync  <= 1'b0;
        end else begin
            data_meta <= mem_data_in;
            data_sync <= data_meta;
            ret_meta  <= retain_req_in;
            ret_sync  <= ret_meta;
        end
    end

    asbt_delay_cnt #(
        .W (`ASBT_CNT_W)
    ) u_cnt (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .load_in    (cnt_load),
        .value_in   (cnt_value),
        .done_out   (cnt_done)
    );

    // new work only in idle; a pending retention request holds it off
    assign req_ready_out = (state == ST_IDLE) && !ret_sync && req_valid_in;
    // selects released before retention is granted
    assign retain_ok_out = (state == ST_RET) &&
        !sel_active(select_low_active_out, select_high_active_out); // [RL13]

    // phase sequencing
    always @* begin
        next_state = state;
        cnt_load   = 1'b0;
        cnt_value  = `ASBT_CNT_ZERO;
        case (state)
            ST_IDLE: begin
                if (ret_sync) begin
                    next_state = ST_RET; // [RL13]
                end else if (req_valid_in && req_write_in) begin
                    // floating gap before host drives the lines
                    next_state = ST_WGAP; // [RL17]
                    cnt_load   = 1'b1;
                    cnt_value  = GAP_CNT;
                end else if (req_valid_in) begin
                    next_state = ST_READ;
                    cnt_load   = 1'b1;
                    cnt_value  = RD_CNT; // [RL8]
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    next_state = ST_REC;
                    cnt_load   = 1'b1;
                    cnt_value  = GAP_CNT; // [RL17]
                end
            end
            ST_WGAP: begin
                if (cnt_done) begin
                    next_state = ST_WRITE;
                    cnt_load   = 1'b1;
                    cnt_value  = WR_CNT; // [RL11] [RL16]
                end
            end
            ST_WRITE: begin
                if (cnt_done) begin
                    next_state = ST_REC;
                    cnt_load   = 1'b1;
                    // two recovery cycles keep the next address clear of write end
                    cnt_value  = `ASBT_CNT_ONE;
                end
            end
            ST_REC: begin
                if (cnt_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RET: begin
                // stay parked with selects off until the request drops
                if (!ret_sync) begin
                    next_state = ST_IDLE;
                end
            end
            // unused codes fall back to idle
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // pin drive: address and data held steady over the whole overlap
    // every memory pin comes from a flip-flop so no glitch reaches the memory strobes
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state                  <= ST_IDLE;
            mem_addr_out           <= {AW{1'b0}};
            select_low_active_out  <= 1'b1;
            select_high_active_out <= 1'b0;
            strobe_n_out           <= 1'b1;
            drive_enable_n_out     <= 1'b1;
            mem_data_out           <= {DW{1'b0}};
            mem_data_oe_out        <= 1'b0;
            rsp_rdata_out          <= {DW{1'b0}};
            rsp_valid_out          <= 1'b0;
        end else begin
            state         <= next_state;
            rsp_valid_out <= 1'b0;
            if (state == ST_IDLE && next_state == ST_READ) begin
                mem_addr_out           <= req_addr_in;
                select_low_active_out  <= 1'b0;
                select_high_active_out <= 1'b1;
                drive_enable_n_out     <= 1'b0; // [RL10]
            end
            if (state == ST_IDLE && next_state == ST_WGAP) begin
                // address and selects go valid with the strobe
                mem_addr_out           <= req_addr_in; // [RL4]
                mem_data_out           <= req_wdata_in;
                select_low_active_out  <= 1'b0;
                select_high_active_out <= 1'b1;
                strobe_n_out           <= 1'b0; // [RL1]
                drive_enable_n_out     <= 1'b1;
            end
            // memory outputs are off by now, so the host may drive
            if (state == ST_WGAP && cnt_done) begin
                mem_data_oe_out <= 1'b1; // [RL17]
            end
            if (state == ST_READ && cnt_done) begin
                // sample after access delay, before any address change
                rsp_rdata_out          <= data_sync; // [RL8] [RL9]
                rsp_valid_out          <= 1'b1;
                drive_enable_n_out     <= 1'b1;
                select_low_active_out  <= 1'b1;
                select_high_active_out <= 1'b0; // [RL15]
            end
            if (state == ST_WRITE && cnt_done) begin
                // strobe and selects end together; this edge ends the write
                strobe_n_out           <= 1'b1; // [RL1] [RL2]
                select_low_active_out  <= 1'b1;
                select_high_active_out <= 1'b0;
                // data and address held to this edge, 0 ns hold
                mem_data_oe_out        <= 1'b0; // [RL3] [RL5] [RL6] [RL7]
            end
        end
    end
endmodule

// [sim/asbt_host_properties.sv]
// pin timing assertions for the async static memory host
`timescale 1ns/1ps
module asbt_host_props #(
    parameter AW = 21,
    parameter DW = 8
) (
    input wire logic          sys_clk_in,             // clock
    input wire logic          nrst_in,                // reset, low
    input wire logic          retain_ok_out,          // retention granted
    input wire logic [AW-1:0] mem_addr_out,           // memory address
    input wire logic          select_low_active_out,  // low select
    input wire logic          select_high_active_out, // high select
    input wire logic          strobe_n_out,           // write strobe
    input wire logic          drive_enable_n_out,     // output enable
    input wire logic [DW-1:0] mem_data_out,           // write data
    input wire logic          mem_data_oe_out         // host drives pins
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // write start and read end events
    sequence s_wr_start; $fell(strobe_n_out); endsequence
    sequence s_rd_end; $rose(drive_enable_n_out); endsequence
    property p_wr_sel; !strobe_n_out |-> !select_low_active_out && select_high_active_out; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("strobe low while deselected");
    property p_addr; !strobe_n_out && !$past(strobe_n_out) |-> $stable(mem_addr_out); endproperty
    a_addr: assert property (p_addr) else $error("address moved inside write");
    property p_data; !strobe_n_out && !$past(strobe_n_out) && $past(mem_data_oe_out)
        |-> $stable(mem_data_out); endproperty
    a_data: assert property (p_data) else $error("write data moved");
    property p_end; $rose(strobe_n_out) |-> $past(mem_data_oe_out); endproperty
    a_end: assert property (p_end) else $error("data not held to write end");
    property p_pulse; s_wr_start |-> !strobe_n_out[*7]; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe pulse short");
    property p_sel; $fell(select_low_active_out) |-> !select_low_active_out[*5]; endproperty
    a_sel: assert property (p_sel) else $error("select pulse short");
    property p_gap_wr; s_wr_start |-> !mem_data_oe_out[*3]; endproperty
    a_gap_wr: assert property (p_gap_wr) else $error("drive too soon after strobe");
    property p_gap_rd; s_rd_end |-> !mem_data_oe_out[*3]; endproperty
    a_gap_rd: assert property (p_gap_rd) else $error("drive too soon after read");
    property p_ret; retain_ok_out |-> select_low_active_out && !select_high_active_out &&
        strobe_n_out && drive_enable_n_out && !mem_data_oe_out; endproperty
    a_ret: assert property (p_ret) else $error("selected in retention");
endmodule
bind asbt_host asbt_host_props #(.AW(AW), .DW(DW)) u_props (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .retain_ok_out(retain_ok_out), .mem_addr_out(mem_addr_out),
    .select_low_active_out(select_low_active_out), .strobe_n_out(strobe_n_out),
    .select_high_active_out(select_high_active_out), .mem_data_out(mem_data_out),
    .drive_enable_n_out(drive_enable_n_out), .mem_data_oe_out(mem_data_oe_out));

// [sim/asbt_sram_model.sv]
// behavioural byte-wide asynchronous static memory
`timescale 1ns/1ps
module asbt_sram_model (
    input  wire logic [20:0] addr_in,  // address
    input  wire logic        sel_n_in, // low select
    input  wire logic        sel_in,   // high select
    input  wire logic        we_n_in,  // write strobe
    input  wire logic        oe_n_in,  // output enable
    input  wire logic [7:0]  pin_in,   // data pins
    output logic      [7:0]  q_out,    // read data
    output logic             drv_out,  // memory drives pins
    output logic      [7:0]  err_out   // host timing faults
);
    logic [7:0] mem [int];
    realtime    t_a = 0;
    realtime    t_d = 0;
    logic       wr_seen = 1'b0;
    wire        sel = !sel_n_in && sel_in;
    wire        wr = sel && !we_n_in;
    wire [7:0]  pin_d;
    wire [20:0] addr_d;
    // one ns of hold on pins and address
    assign #1 pin_d = pin_in;
    assign #1 addr_d = addr_in;
    initial q_out = 8'h00;
    initial drv_out = 1'b0;
    initial err_out = 8'h00;
    always @(addr_in) t_a = $realtime;
    always @(pin_d) t_d = $realtime;
    // drive starts slower than it stops
    always @(sel or we_n_in or oe_n_in) if (sel && we_n_in && !oe_n_in) drv_out <= #10 1'b1;
        else drv_out <= #5 1'b0;
    // old data briefly, then new data inside access time
    always @(addr_in) begin
        q_out <= #10 ~q_out;
        q_out <= #40 (mem.exists(addr_in) ? mem[addr_in] : 8'h00);
    end
    // store at the edge that ends the overlap, check setups
    // only a real overlap ends a write, not the power-on unknown
    always @(posedge wr) wr_seen = 1'b1;
    always @(negedge wr) if (wr_seen) begin
        wr_seen = 1'b0;
        mem[addr_d] = pin_d;
        if ($realtime - t_d < 25 || $realtime - t_a < 35) err_out = err_out + 8'h01;
    end
endmodule

// [sim/asbt_host_test.sv]
// self-checking bench for the async static memory host
`timescale 1ns/1ps
module asbt_host_test;
    logic        clk = 1'b0, nrst = 1'b0, vld = 1'b0, wr = 1'b0, ret = 1'b0;
    logic [20:0] addr = 21'h00_0000;
    logic [20:0] a;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  ref_m [int];
    wire         rdy, rv, rok, sl, sh, we_n, oe_n, doe, drv;
    wire  [20:0] ma;
    wire  [7:0]  rd, dout, q, err;
    wire  [7:0]  pin = doe ? dout : (drv ? q : ~q);
    int          fail_count = 0, checks = 0, cyc = 0, seed, n;
    asbt_host DUT (.sys_clk_in(clk), .nrst_in(nrst), .req_valid_in(vld), .req_write_in(wr),
        .req_addr_in(addr), .req_wdata_in(wd), .req_ready_out(rdy), .rsp_rdata_out(rd),
        .rsp_valid_out(rv), .retain_req_in(ret), .retain_ok_out(rok), .mem_addr_out(ma),
        .select_low_active_out(sl), .select_high_active_out(sh), .strobe_n_out(we_n),
        .drive_enable_n_out(oe_n), .mem_data_in(pin), .mem_data_out(dout),
        .mem_data_oe_out(doe));
    asbt_sram_model mem (.addr_in(ma), .sel_n_in(sl), .sel_in(sh), .we_n_in(we_n),
        .oe_n_in(oe_n), .pin_in(pin), .q_out(q), .drv_out(drv), .err_out(err));
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // one request, held until taken; reads compared with reference
    task automatic req(input logic w, input logic [20:0] ad, input logic [7:0] d);
        int k;
        k = 0;
        vld <= 1'b1;
        wr <= w;
        addr <= ad;
        wd <= d;
        do begin @(negedge clk); k++; end while (rdy !== 1'b1 && k < 40);
        check(rdy === 1'b1, "request not taken");
        @(posedge clk);
        vld <= 1'b0;
        if (w) ref_m[ad] = d;
        else begin
            k = 0;
            do begin @(negedge clk); k++; end while (rv !== 1'b1 && k < 30);
            check(rv === 1'b1 && rd === ref_m[ad], "read data wrong");
        end
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        seed = $urandom(6);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // corner addresses back to back
        req(1'b1, 21'h00_0000, 8'hA5);
        req(1'b1, 21'h1F_FFFF, 8'h5A);
        req(1'b0, 21'h00_0000, 8'h00);
        req(1'b0, 21'h1F_FFFF, 8'h00);
        $display("corner test done");
        // random mix over a small pool
        for (int i = 0; i < 40; i++) begin
            a = 21'($urandom % 16);
            if (!ref_m.exists(a) || $urandom % 2) req(1'b1, a, 8'($urandom));
            else req(1'b0, a, 8'h00);
        end
        check(err === 8'h00, "memory saw write timing fault");
        $display("random test done");
        // retention entry and exit
        ret <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (rok !== 1'b1 && n < 20);
        check(rok === 1'b1 && sl === 1'b1 && sh === 1'b0 && rdy === 1'b0, "no retention");
        @(posedge clk);
        ret <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (rok !== 1'b0 && n < 20);
        @(posedge clk);
        req(1'b0, 21'h1F_FFFF, 8'h00);
        $display("retention test done");
        end_sim();
    end
endmodule
